// ---- src/rmc_pkg.sv ----
/*
  Package for the ring and metering control block: mode codes, timing
  constants and envelope shaping constants.
  Assumes a 50 MHz system clock.
*/
package rmc_pkg;
  // ==========================================================
  // Modes
  typedef enum logic [2:0] {
    RMC_MODE_POWER_DOWN,
    RMC_MODE_HIGH_Z,
    RMC_MODE_ACTIVE,
    RMC_MODE_ACTIVE_METER,
    RMC_MODE_RINGING
  } rmc_mode_type;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned RAMP_TIME_US = 2000;
  localparam int unsigned RAMP_CYCLES = (RAMP_TIME_US * (CLK_HZ / 1000000));
  localparam int unsigned ENV_RISE_TIME_US = 6000;
  localparam int unsigned ENV_STEP_CYCLES = (ENV_RISE_TIME_US * (CLK_HZ / 1000000)) / 256;
  localparam int unsigned RAMP_W = 8;
  localparam logic [RAMP_W-1:0] RAMP_MAX = 8'hFF;
  localparam logic [RAMP_W-1:0] RAMP_ZERO = 8'h00;
  localparam logic [RAMP_W-1:0] ENV_MAX = 8'hFF;
  localparam logic [RAMP_W-1:0] ENV_ZERO = 8'h00;
  localparam logic [3:0] EVT_RING_TRIP = 4'h1;
  localparam logic [3:0] EVT_OFF_HOOK = 4'h2;
  localparam logic [3:0] EVT_BURST_END = 4'h4;
  localparam logic [3:0] EVT_POL_DONE = 4'h8;
endpackage

// ---- src/rmc_ramp.sv ----
/*
  Slew limiter: a level moves one step per tick toward its target.
  Assumes one clock, asynchronous active-high reset.
*/
`timescale 1ns/10ps
module rmc_ramp #(
  parameter int unsigned TICK_CYCLES = 16,
  parameter int unsigned W = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] target_i,
  output logic [W-1:0] level_o,
  output logic settled_o
);
  typedef struct packed {
    logic [W-1:0] level;
    logic [31:0] tick;
  } rmc_ramp_state_type;

  rmc_ramp_state_type state_q;
  rmc_ramp_state_type state_d;

  always_comb begin
    state_d = state_q;
    if (state_q.tick >= TICK_CYCLES - 1) begin
      state_d.tick = '0;
      if (state_q.level < target_i) begin
        state_d.level = state_q.level + 1'b1;
      end else if (state_q.level > target_i) begin
        state_d.level = state_q.level - 1'b1;
      end
    end else begin
      state_d.tick = state_q.tick + 32'd1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign level_o = state_q.level;
  assign settled_o = (state_q.level == target_i);
endmodule // rmc_ramp

// ---- src/rmc_core.sv ----
/*
  Device-side ring and metering control: decodes the mode control bits,
  shapes polarity ramps and metering burst envelopes, reports hook status
  on an open-drain output, and offers an Avalon-MM register slave with
  sticky event status, mask and interrupt.
  Assumes control inputs and line sense are synchronous to clk_sys_i.
*/
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module rmc_core #(
  parameter int unsigned RAMP_CYCLES = rmc_pkg::RAMP_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic power_on_ctrl_i,
  input wire logic tone_ctrl_bit_i,
  input wire logic feed_ctrl_bit_i,
  input wire logic polarity_ctrl_bit_i,
  input wire logic metering_tone_clock_i,
  input wire logic loop_current_i,
  input wire logic ring_trip_sense_i,
  output logic hook_status_n_o,
  output logic hook_status_n_oe_o,
  output logic shaped_square_burst_o,
  output logic [7:0] burst_envelope_o,
  output logic [7:0] line_polarity_level_o,
  output logic ringing_o,
  output logic [2:0] mode_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);
  // ==========================================================
  // Register map
  // Word 0 status, sticky events, write one to clear
  // Word 1 mask, same layout as status
  // Word 2 live mode, ramp, burst and hook flags, read only
  // Word 3 ring trip detect enable
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_MODE = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  // A ramp spans 256 levels; never let the tick drop to zero
  localparam int unsigned POL_TICK =
    (RAMP_CYCLES / 256) > 0 ? (RAMP_CYCLES / 256) : 1;
  localparam int unsigned ENV_TICK =
    rmc_pkg::ENV_STEP_CYCLES > 0 ? rmc_pkg::ENV_STEP_CYCLES : 1;

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] mask;
    logic ring_trip_en;
    logic [31:0] rdata;
    logic ack;
    logic hook_low;
    logic burst_on;
    logic pol_settled;
    logic burst_out;
  } rmc_state_type;

  rmc_state_type state_q;
  rmc_state_type state_d;
  rmc_pkg::rmc_mode_type mode;
  logic [7:0] pol_target;
  logic [7:0] env_target;
  logic [7:0] pol_level;
  logic [7:0] env_level;
  logic pol_settled;
  logic env_settled;
  logic [3:0] events;
  logic hook_low_now;

  // ==========================================================
  // Mode decode
  // Power bit low forces power down whatever the others say
  always_comb begin
    if (!power_on_ctrl_i && !tone_ctrl_bit_i && !feed_ctrl_bit_i) begin
      mode = rmc_pkg::RMC_MODE_POWER_DOWN;
    end else if (!power_on_ctrl_i) begin
      mode = rmc_pkg::RMC_MODE_POWER_DOWN;
    end else if (!tone_ctrl_bit_i && !feed_ctrl_bit_i) begin
      mode = rmc_pkg::RMC_MODE_HIGH_Z;
    end else if (!tone_ctrl_bit_i) begin
      mode = rmc_pkg::RMC_MODE_ACTIVE;
    end else if (feed_ctrl_bit_i) begin
      mode = rmc_pkg::RMC_MODE_ACTIVE_METER;
    end else begin
      mode = rmc_pkg::RMC_MODE_RINGING;
    end
  end

  // ==========================================================
  // Polarity ramp and metering envelope
  assign pol_target = polarity_ctrl_bit_i ? rmc_pkg::RAMP_MAX : rmc_pkg::RAMP_ZERO;
  assign env_target = (mode == rmc_pkg::RMC_MODE_ACTIVE_METER) ?
    rmc_pkg::ENV_MAX : rmc_pkg::ENV_ZERO;

  rmc_ramp #(.TICK_CYCLES(POL_TICK), .W(8)) u_pol_ramp (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .target_i(pol_target),
    .level_o(pol_level),
    .settled_o(pol_settled)
  );

  rmc_ramp #(.TICK_CYCLES(ENV_TICK), .W(8)) u_env_ramp (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .target_i(env_target),
    .level_o(env_level),
    .settled_o(env_settled)
  );

  // ==========================================================
  // Hook detection: disabled in power down
  // Ring trip sense counts only in ringing mode
  assign hook_low_now = (mode != rmc_pkg::RMC_MODE_POWER_DOWN) &&
    ((mode == rmc_pkg::RMC_MODE_RINGING) ? (ring_trip_sense_i && state_q.ring_trip_en)
                                         : loop_current_i);

  always_comb begin
    events = 4'h0;
    if (hook_low_now && !state_q.hook_low) begin
      events = (mode == rmc_pkg::RMC_MODE_RINGING) ?
        rmc_pkg::EVT_RING_TRIP : rmc_pkg::EVT_OFF_HOOK;
    end
    // Burst end fires once, as the envelope reaches zero
    if (state_q.burst_on && env_settled && env_target == rmc_pkg::ENV_ZERO) begin
      events = events | rmc_pkg::EVT_BURST_END;
    end
    if (pol_settled && !state_q.pol_settled) begin
      events = events | rmc_pkg::EVT_POL_DONE;
    end
  end

  // ==========================================================
  // Register file and state update
  always_comb begin
    state_d = state_q;
    state_d.hook_low = hook_low_now;
    state_d.pol_settled = pol_settled;
    if (env_target != rmc_pkg::ENV_ZERO) begin
      state_d.burst_on = 1'b1;
    end else if (env_settled) begin
      state_d.burst_on = 1'b0;
    end
    // Tone passes only while a burst is under way
    state_d.burst_out = metering_tone_clock_i && state_d.burst_on;
    // One wait state: a request is taken in its second cycle
    state_d.ack = (avs_read_i || avs_write_i) && !state_q.ack;
    state_d.rdata = '0;
    // Unmapped words read zero and ignore writes
    if (avs_read_i && !state_q.ack) begin
      unique case (avs_address_i)
        REG_STATUS: state_d.rdata = {28'h000_0000, state_q.status};
        REG_MASK: state_d.rdata = {28'h000_0000, state_q.mask};
        REG_MODE: state_d.rdata = {24'h00_0000, state_q.hook_low, state_q.burst_on,
                                   pol_settled, 2'b00, mode};
        REG_CTRL: state_d.rdata = {31'h0000_0000, state_q.ring_trip_en};
        default: state_d.rdata = '0;
      endcase
    end
    // Writes land only at the edge where waitrequest is low
    if (avs_write_i && state_q.ack) begin
      unique case (avs_address_i)
        REG_STATUS: state_d.status = state_q.status & ~avs_writedata_i[3:0];
        REG_MASK: state_d.mask = avs_writedata_i[3:0];
        REG_CTRL: state_d.ring_trip_en = avs_writedata_i[0];
        default: state_d.mask = state_q.mask;
      endcase
    end
    // A new event beats a clear in the same cycle
    state_d.status = state_d.status | events;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= '{
        status: 4'h0,
        mask: 4'h0,
        ring_trip_en: 1'b1,
        rdata: 32'h0000_0000,
        ack: 1'b0,
        hook_low: 1'b0,
        burst_on: 1'b0,
        pol_settled: 1'b1,
        burst_out: 1'b0
      };
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  // Open drain: data stays low, the enable pulls the line
  assign hook_status_n_o = 1'b0;
  assign hook_status_n_oe_o = state_q.hook_low;
  assign shaped_square_burst_o = state_q.burst_out;
  assign burst_envelope_o = env_level;
  assign line_polarity_level_o = pol_level;
  assign ringing_o = (mode == rmc_pkg::RMC_MODE_RINGING);
  assign mode_o = mode;
  assign avs_readdata_o = state_q.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !state_q.ack;
  assign irq_o = |(state_q.status & state_q.mask);
endmodule // rmc_core

// ---- verif/rmc_core_properties.sv ----
/*
  Port assertions for rmc_core.
  Assumes one clock and the bench below driving every input.
*/
`timescale 1ns/10ps
module rmc_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic power_on_ctrl_i,
  input wire logic tone_ctrl_bit_i,
  input wire logic feed_ctrl_bit_i,
  input wire logic polarity_ctrl_bit_i,
  input wire logic metering_tone_clock_i,
  input wire logic loop_current_i,
  input wire logic ring_trip_sense_i,
  input wire logic hook_status_n_oe_o,
  input wire logic shaped_square_burst_o,
  input wire logic [7:0] line_polarity_level_o,
  input wire logic ringing_o,
  input wire logic [2:0] mode_o,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // Sequences
  sequence pol_hi_s;
    (mode_o >= 3'h2 && polarity_ctrl_bit_i)[*4];
  endsequence
  sequence trip_s;
    (ringing_o && ring_trip_sense_i)[*2];
  endsequence
  // ==========================================================
  // Properties
  a_ring_mode: assert property (power_on_ctrl_i && tone_ctrl_bit_i &&
    !feed_ctrl_bit_i |-> ringing_o && mode_o == 3'h4) else $error("ring mode wrong");
  a_meter_mode: assert property (power_on_ctrl_i && tone_ctrl_bit_i &&
    feed_ctrl_bit_i |-> mode_o == 3'h3) else $error("meter mode wrong");
  a_burst_gate: assert property (shaped_square_burst_o |->
    $past(metering_tone_clock_i)) else $error("burst without tone");
  a_pol_rise: assert property (pol_hi_s |=>
    line_polarity_level_o >= $past(line_polarity_level_o)) else $error("polarity fell");
  a_trip_hook: assert property (trip_s |-> ##[0:2] hook_status_n_oe_o)
    else $error("ring trip not shown");
  a_loop_hook: assert property ((mode_o == 3'h2 && loop_current_i)[*2] |->
    ##[0:2] hook_status_n_oe_o) else $error("off hook not shown");
  a_pd_quiet: assert property ((mode_o == 3'h0)[*4] |-> !hook_status_n_oe_o)
    else $error("hook in power down");
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("wait too long");
endmodule // rmc_chk

bind rmc_core rmc_chk u_chk (.*);

// ---- verif/rmc_ctrl_model.sv ----
/*
  Card controller model: tone clock, ring toggling, hook sync.
  Assumes hook_line_i is the pulled-up hook wire.
*/
`timescale 1ns/10ps
module rmc_ctrl_model #(
  parameter int HALF = 2083,
  parameter int TOG = 1500
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ring_en_i,
  input wire logic pol_req_i,
  input wire logic hook_line_i,
  output logic tone_clk_o,
  output logic polarity_o
);
  logic [1:0] sync_q;
  logic trip_q;
  int tc;
  int rc;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_q <= 2'h3;
      trip_q <= 1'b0;
      tc <= 0;
      rc <= 0;
      tone_clk_o <= 1'b0;
      polarity_o <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], hook_line_i};
      tc <= (tc == HALF - 1) ? 0 : tc + 1;
      if (tc == HALF - 1) tone_clk_o <= !tone_clk_o;
      trip_q <= ring_en_i && (trip_q || !sync_q[1]);
      rc <= (rc == TOG - 1) ? 0 : rc + 1;
      if (!ring_en_i) polarity_o <= pol_req_i;
      else if (!trip_q && rc == TOG - 1) polarity_o <= !polarity_o;
    end
  end
endmodule // rmc_ctrl_model

// ---- verif/ring_and_metering_control_tb.sv ----
/*
  Self-checking bench for rmc_core with a controller model.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ring_and_metering_control_tb;
  localparam logic [2:0] CFG [5] = '{3'h0, 3'h4, 3'h5, 3'h7, 3'h6};
  localparam logic [2:0] MOD [5] = '{rmc_pkg::RMC_MODE_POWER_DOWN,
    rmc_pkg::RMC_MODE_HIGH_Z, rmc_pkg::RMC_MODE_ACTIVE,
    rmc_pkg::RMC_MODE_ACTIVE_METER, rmc_pkg::RMC_MODE_RINGING};
  logic clk_sys_i, sys_rst_i, pwr, tone, feed, loop_i, trip_i, ring_en, pol_req;
  logic rd, wr, tclk, pol, wrq, oe, hook_n, burst, ringing, irq, seen;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  logic [7:0] env, lvl, l;
  logic [2:0] mode;
  int n_mismatch, check_count, i;
  wire hook_line = oe ? hook_n : 1'b1;
  rmc_core #(.RAMP_CYCLES(512)) u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .power_on_ctrl_i(pwr), .tone_ctrl_bit_i(tone), .feed_ctrl_bit_i(feed),
    .polarity_ctrl_bit_i(pol), .metering_tone_clock_i(tclk), .loop_current_i(loop_i),
    .ring_trip_sense_i(trip_i), .hook_status_n_o(hook_n), .hook_status_n_oe_o(oe),
    .shaped_square_burst_o(burst), .burst_envelope_o(env), .line_polarity_level_o(lvl),
    .ringing_o(ringing), .mode_o(mode), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wrq), .irq_o(irq));
  rmc_ctrl_model u_ctl (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .ring_en_i(ring_en), .pol_req_i(pol_req), .hook_line_i(hook_line),
    .tone_clk_o(tclk), .polarity_o(pol));
  // ==========================================================
  // Tasks
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task set_mode(input logic [2:0] c);
    @(posedge clk_sys_i);
    {pwr, tone, feed} <= c;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    i = 0;
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (wrq !== 1'b0 && i < 20);
    if (wrq !== 1'b0) begin
      n_mismatch++;
      summarize();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wait_lvl(input logic [7:0] v);
    for (i = 0; i < 5000 && lvl !== v; i++) @(posedge clk_sys_i);
    `CHK(lvl, v)
    if (lvl !== v) summarize();
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    bus(0, 4'h3, '0);
    `CHK(q, 32'h0000_0001)
    bus(1, 4'hf, 32'hffff_ffff);
    bus(0, 4'hf, '0);
    `CHK(q, 32'h0000_0000)
    bus(0, 4'h1, '0);
    `CHK(q, 32'h0000_0000)
  endtask
  task t_modes;
    for (int k = 0; k < 5; k++) begin
      set_mode(CFG[k]);
      cyc(5);
      @(negedge clk_sys_i);
      `CHK(mode, MOD[k])
    end
    set_mode(3'h5);
    loop_i <= 1'b1;
    cyc(6);
    `CHK(hook_line, 1'b0)
    bus(0, 4'h0, '0);
    `CHK(q[1], 1'b1)
    loop_i <= 1'b0;
  endtask
  task t_pol;
    pol_req <= 1'b1;
    cyc(100);
    `CHK(lvl > 8'h00 && lvl < 8'hff, 1'b1)
    wait_lvl(8'hff);
    pol_req <= 1'b0;
    wait_lvl(8'h00);
  endtask
  task t_meter;
    set_mode(3'h7);
    seen = 1'b0;
    repeat (5000) @(negedge clk_sys_i) seen |= burst;
    `CHK(seen, 1'b1)
    `CHK(env > 8'h00, 1'b1)
    l = env;
    set_mode(3'h5);
    cyc(3000);
    `CHK(env < l, 1'b1)
    for (i = 0; i < 6000 && env !== 8'h00; i++) @(posedge clk_sys_i);
    `CHK(env, 8'h00)
    if (env !== 8'h00) summarize();
    cyc(2);
    seen = 1'b0;
    repeat (4200) @(negedge clk_sys_i) seen |= burst;
    `CHK(seen, 1'b0)
  endtask
  task t_ring;
    bus(1, 4'h1, '0);
    set_mode(3'h6);
    ring_en <= 1'b1;
    wait_lvl(8'hff);
    wait_lvl(8'h00);
    trip_i <= 1'b1;
    for (i = 0; i < 100 && hook_line !== 1'b0; i++) @(negedge clk_sys_i);
    `CHK(hook_line, 1'b0)
    if (i == 100) summarize();
    bus(0, 4'h0, '0);
    trip_i <= 1'b0;
    `CHK(q[0], 1'b1)
    `CHK(irq, 1'b0)
    bus(1, 4'h1, 32'h0000_0001);
    @(negedge clk_sys_i);
    `CHK(irq, 1'b1)
    bus(1, 4'h0, 32'h0000_0001);
    bus(0, 4'h0, '0);
    `CHK(q[0], 1'b0)
    `CHK(irq, 1'b0)
    l = lvl;
    cyc(3200);
    `CHK(lvl, l)
    ring_en <= 1'b0;
  endtask
  task t_reset;
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    cyc(2);
    sys_rst_i <= 1'b0;
    `CHK({oe, burst, irq, lvl, env}, 19'h0_0000)
    bus(0, 4'h3, '0);
    `CHK(q, 32'h0000_0001)
    bus(0, 4'h0, '0);
    `CHK(q, 32'h0000_0000)
  endtask
  // ==========================================================
  // Clock and main sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = !clk_sys_i;
  end
  initial begin
    {sys_rst_i, pwr, tone, feed, loop_i, trip_i, ring_en, pol_req, rd, wr} = 10'h200;
    adr = '0;
    wd = '0;
    n_mismatch = 0;
    check_count = 0;
    cyc(10);
    sys_rst_i <= 1'b0;
    t_regs;
    t_modes;
    t_pol;
    t_meter;
    t_ring;
    t_reset;
    summarize;
  end
endmodule // ring_and_metering_control_tb
